// file: ipc_counter.v
// Purpose: Input pulse counter with Wishbone register access
// Assumes: Pulse and clear inputs are asynchronous digital pins
// Notes: Rates well below the clock; each pulse is one rising edge
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ipc_defines.vh"

// Behaviour
// - Counting function starts when execute goes from low to high with an index of at most 6.
// - Pulses come from the input selected by the source channel field.
// - Counting only happens while start is high.
// - While software clear is high the count is forced to zero.
// - Level external clear zeroes the count while the clear input is high.
// - Falling-edge external clear zeroes the count on each falling edge.
// - Rising-edge external clear zeroes the count on each rising edge.
// - Clear channel 0-7 picks I0-I7, 8-15 picks I10-I17.
// - Direction zero counts down, direction one counts up.
// - Cyclic mode clears the count on reaching the cycle value.
// - With cyclic mode off the count never wraps at the cycle value.
// - While preset enable is high and no clear is active the preset value is loaded.
// - Count stays zero during clear, resumes from zero after release.
// - Counting in hardware, independent of software, up to 5 kHz.
// - Count reported signed; busy and valid high while executing with an index of at most 6.
module ipc_counter #(
  parameter CNT_W = 32,
  parameter CH_N = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [CH_N-1:0] di_i,
  output reg [CNT_W-1:0] count_o,
  output reg busy_o,
  output reg valid_o,
  output reg error_o
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg [`IPC_CTRL_W-1:0] ctrl_q;
  reg [31:0] sel_q;
  reg [CNT_W-1:0] cycle_q;
  reg [CNT_W-1:0] preset_q;
  reg [CNT_W-1:0] count_q;
  reg [CNT_W-1:0] count_d;
  reg exec_q;
  reg run_q;
  reg err_q;

  wire bus_req;
  wire wr_en;
  wire [31:0] byte_mask;
  wire [31:0] ctrl_wide;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = bus_req & wb_we_i;
  assign ctrl_wide = {{(32-`IPC_CTRL_W){1'b0}}, ctrl_q};

  // ----------------------------------------------------------------
  // Byte lane mask
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign byte_mask[g*8+7:g*8] = {8{wb_sel_i[g]}};
    end
  endgenerate

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] mask;
    begin
      merge = (old_v & ~mask) | (new_v & mask);
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [CH_N-1:0] di_meta_q;
  reg [CH_N-1:0] di_sync_q;
  reg [CH_N-1:0] di_prev_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      di_meta_q <= {CH_N{1'b0}};
      di_sync_q <= {CH_N{1'b0}};
      di_prev_q <= {CH_N{1'b0}};
    end else begin
      di_meta_q <= di_i;
      di_sync_q <= di_meta_q;
      di_prev_q <= di_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Channel selection
  // ----------------------------------------------------------------
  wire [3:0] src_ch;
  wire [3:0] clr_ch;
  wire [2:0] idx;
  wire pulse_now;
  wire pulse_prev;
  wire xclr_now;
  wire xclr_prev;

  assign idx = sel_q[`IPC_SEL_IDX_HI:`IPC_SEL_IDX_LO];
  assign src_ch = sel_q[`IPC_SEL_SRC_HI:`IPC_SEL_SRC_LO];
  assign clr_ch = sel_q[`IPC_SEL_CLR_HI:`IPC_SEL_CLR_LO];

  assign pulse_now = di_sync_q[src_ch];
  assign pulse_prev = di_prev_q[src_ch];
  // Clear point pick, I10-I17 on bits 8-15
  assign xclr_now = di_sync_q[clr_ch];
  assign xclr_prev = di_prev_q[clr_ch];

  // ----------------------------------------------------------------
  // Clear, preset and count conditions
  // ----------------------------------------------------------------
  wire pulse_edge;
  wire do_count;
  wire clr_sw;
  wire clr_lvl;
  wire clr_fall;
  wire clr_rise;
  wire clr_any;
  wire idx_ok;

  assign idx_ok = (idx <= `IPC_IDX_MAX);
  // Hardware edge detection on pulse input
  assign pulse_edge = pulse_now & ~pulse_prev;
  assign do_count = run_q & ctrl_q[`IPC_CTRL_START] & pulse_edge;
  assign clr_sw = ctrl_q[`IPC_CTRL_CLEAR];
  assign clr_lvl = ctrl_q[`IPC_CTRL_LVL] & xclr_now;
  assign clr_fall = ctrl_q[`IPC_CTRL_FALL] & ~xclr_now & xclr_prev;
  assign clr_rise = ctrl_q[`IPC_CTRL_RISE] & xclr_now & ~xclr_prev;
  assign clr_any = clr_sw | clr_lvl | clr_fall | clr_rise;

  // ----------------------------------------------------------------
  // Next count
  // ----------------------------------------------------------------
  reg [CNT_W-1:0] step_v;

  always @* begin
    step_v = count_q;
    count_d = count_q;
    if (ctrl_q[`IPC_CTRL_UP]) begin
      step_v = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      step_v = count_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
    // Clear first, then preset, then count
    if (clr_any) begin
      count_d = {CNT_W{1'b0}};
    end else if (ctrl_q[`IPC_CTRL_PRE]) begin
      count_d = preset_q;
    end else if (do_count) begin
      // Wrap to zero at cycle value
      if (ctrl_q[`IPC_CTRL_CYC] && step_v == cycle_q) begin
        count_d = {CNT_W{1'b0}};
      end else begin
        count_d = step_v;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= {CNT_W{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Execute control
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      exec_q <= 1'b0;
      run_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      exec_q <= ctrl_q[`IPC_CTRL_EXEC];
      if (ctrl_q[`IPC_CTRL_EXEC] & ~exec_q) begin
        run_q <= idx_ok;
        err_q <= ~idx_ok;
      end else if (~ctrl_q[`IPC_CTRL_EXEC]) begin
        run_q <= 1'b0;
        err_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= {CNT_W{1'b0}};
      busy_o <= 1'b0;
      valid_o <= 1'b0;
      error_o <= 1'b0;
    end else begin
      count_o <= count_q;
      busy_o <= run_q;
      valid_o <= run_q;
      error_o <= err_q;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  wire [31:0] ctrl_new;
  assign ctrl_new = merge(ctrl_wide, wb_dat_i, byte_mask);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `IPC_RST_CTRL;
      sel_q <= `IPC_RST_SEL;
      cycle_q <= `IPC_RST_CYCLE;
      preset_q <= `IPC_RST_PRESET;
    end else if (wr_en) begin
      case (wb_adr_i)
        `IPC_OFS_CTRL: begin
          ctrl_q <= ctrl_new[`IPC_CTRL_W-1:0];
        end
        `IPC_OFS_SEL: begin
          sel_q <= merge(sel_q, wb_dat_i, byte_mask) & 32'h000F0F07;
        end
        `IPC_OFS_CYCLE: begin
          cycle_q <= merge(cycle_q, wb_dat_i, byte_mask);
        end
        `IPC_OFS_PRESET: begin
          preset_q <= merge(preset_q, wb_dat_i, byte_mask);
        end
        default: begin
          ctrl_q <= ctrl_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads and acknowledge
  // ----------------------------------------------------------------
  reg [31:0] rd_v;

  always @* begin
    rd_v = 32'h00000000;
    case (wb_adr_i)
      `IPC_OFS_CTRL: rd_v = ctrl_wide;
      `IPC_OFS_SEL: rd_v = sel_q;
      `IPC_OFS_CYCLE: rd_v = cycle_q;
      `IPC_OFS_PRESET: rd_v = preset_q;
      `IPC_OFS_COUNT: rd_v = count_q;
      `IPC_OFS_STATUS: begin
        rd_v[`IPC_STAT_BUSY] = run_q;
        rd_v[`IPC_STAT_VALID] = run_q;
        rd_v[`IPC_STAT_ERR] = err_q;
        rd_v[31:16] = err_q ? `IPC_ERRID_IDX : 16'h0000;
      end
      default: rd_v = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_v : 32'h00000000;
    end
  end

endmodule

// file: ipc_counter_checker.sv
// Purpose: Port checker for the pulse counter
// Assumes: Ack one cycle after a taken request
// Notes: Bound to every counter instance
`timescale 1ns/1ps
module ipc_counter_checker #(
  parameter CNT_W = 32,
  parameter CH_N = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [CH_N-1:0] di_i,
  input wire [CNT_W-1:0] count_o,
  input wire busy_o,
  input wire valid_o,
  input wire error_o
);
  logic [CH_N-1:0] di_q;
  logic [2:0] quiet_q;
  logic [2:0] bus_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------
  // Cycles since a pin change or a bus answer
  // ----------
  always @(posedge clk_i) begin
    di_q <= di_i;
    if (rst_i || di_i != di_q || wb_ack_o) begin
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h7) begin
      quiet_q <= quiet_q + 3'h1;
    end
    if (rst_i || wb_ack_o) begin
      bus_q <= 3'h0;
    end else if (bus_q != 3'h7) begin
      bus_q <= bus_q + 3'h1;
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_next;
    s_req |=> s_ack;
  endproperty
  property p_dat_zero;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  property p_valid_busy;
    valid_o == busy_o;
  endproperty
  property p_err_nobusy;
    error_o |-> !busy_o;
  endproperty
  property p_err_cause;
    $rose(error_o) |-> bus_q < 3'h6;
  endproperty
  property p_busy_cause;
    $rose(busy_o) |-> bus_q < 3'h6;
  endproperty
  property p_quiet;
    quiet_q == 3'h7 |-> $stable(count_o);
  endproperty
  property p_step;
    bus_q == 3'h7 && !$stable(count_o) |-> count_o == '0 ||
      count_o == $past(count_o) + 1 || count_o == $past(count_o) - 1;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack timing");
  a_dat_zero: assert property (p_dat_zero) else $error("data not zero");
  a_valid_busy: assert property (p_valid_busy) else $error("valid");
  a_err_nobusy: assert property (p_err_nobusy) else $error("busy");
  a_err_cause: assert property (p_err_cause) else $error("error");
  a_busy_cause: assert property (p_busy_cause) else $error("run");
  a_quiet: assert property (p_quiet) else $error("count moved");
  a_step: assert property (p_step) else $error("count step");
endmodule
bind ipc_counter ipc_counter_checker #(.CNT_W(CNT_W), .CH_N(CH_N))
  ipc_counter_checker_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .di_i(di_i), .count_o(count_o),
  .busy_o(busy_o), .valid_o(valid_o), .error_o(error_o));

// file: ipc_counter_tb_top.sv
// Purpose: Self-checking bench for the pulse counter
// Assumes: Pulses on pin 3, cycle value 3, preset 0x64
// Notes: Reset checks first, then row table, then hand tests
`timescale 1ns/1ps
`include "ipc_defines.vh"
module ipc_counter_tb_top;
  typedef struct {
    logic [8:0] c;
    logic [31:0] s;
    int n;
    int m;
    logic [31:0] e;
  } ipc_row_t;
  ipc_row_t rows [12];
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [3:0] wsel = 4'hF;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic [31:0] cnt;
  logic [15:0] di;
  logic ack, busy, valid, err;
  int n_mismatch = 0;
  int compares = 0;
  ipc_counter ipc_counter_i (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .di_i(di),
    .count_o(cnt), .busy_o(busy), .valid_o(valid), .error_o(err));
  ipc_pulse_src ipc_pulse_src_i (.clk_i(clk), .di_o(di));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= wsel;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial begin
    rows = '{'{9'h043, 32'h000A0300, 3, 2, 32'h5},
      '{9'h003, 32'h000A0300, 3, 0, 32'hFFFFFFFD},
      '{9'h041, 32'h000A0300, 3, 0, 32'h0},
      '{9'h043, 32'h000A0900, 3, 0, 32'h0},
      '{9'h0C3, 32'h000A0300, 5, 0, 32'h2},
      '{9'h047, 32'h000A0300, 3, 0, 32'h0},
      '{9'h143, 32'h000A0300, 2, 0, 32'h64},
      '{9'h147, 32'h000A0300, 2, 0, 32'h0},
      '{9'h04B, 32'h000A0300, 3, 2, 32'h0},
      '{9'h053, 32'h000A0300, 3, 2, 32'h0},
      '{9'h063, 32'h000A0300, 3, 2, 32'h2},
      '{9'h063, 32'h00050306, 3, 2, 32'h2}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, `IPC_OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h00000040);
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, `IPC_OFS_CYCLE, 32'h3);
    wb(1'b1, `IPC_OFS_PRESET, 32'h64);
    $display("test reset done");
    foreach (rows[i]) begin
      wb(1'b1, `IPC_OFS_CTRL, 32'h4);
      wb(1'b1, `IPC_OFS_SEL, rows[i].s);
      wb(1'b1, `IPC_OFS_CTRL, {23'h0, rows[i].c});
      repeat (rows[i].n) ipc_pulse_src_i.pulse(4'h3);
      ipc_pulse_src_i.pin(rows[i].s[19:16], 1'b1);
      repeat (rows[i].m) ipc_pulse_src_i.pulse(4'h3);
      ipc_pulse_src_i.pin(rows[i].s[19:16], 1'b0);
      wb(1'b0, `IPC_OFS_COUNT, 32'h0);
      chk("count", rd, rows[i].e);
      chk("count_o", cnt, rows[i].e);
      $display("test row %0d done", i);
    end
    wb(1'b1, `IPC_OFS_CTRL, 32'h40);
    wb(1'b1, `IPC_OFS_SEL, 32'h000A0307);
    wb(1'b1, `IPC_OFS_CTRL, 32'h43);
    wb(1'b0, `IPC_OFS_STATUS, 32'h0);
    chk("status", rd, 32'h00010004);
    chk("error_o busy_o", {30'h0, err, busy}, 32'h2);
    $display("test index done");
    wb(1'b1, `IPC_OFS_CTRL, 32'h40);
    wb(1'b1, `IPC_OFS_SEL, 32'h000A0300);
    wb(1'b1, `IPC_OFS_CTRL, 32'h143);
    wb(1'b1, `IPC_OFS_CTRL, 32'h43);
    repeat (2) ipc_pulse_src_i.pulse(4'h3);
    wb(1'b0, `IPC_OFS_COUNT, 32'h0);
    chk("count", rd, 32'h66);
    chk("busy_o valid_o", {30'h0, busy, valid}, 32'h3);
    wb(1'b1, `IPC_OFS_CTRL, 32'h47);
    ipc_pulse_src_i.pulse(4'h3);
    wb(1'b1, `IPC_OFS_CTRL, 32'h43);
    repeat (2) ipc_pulse_src_i.pulse(4'h3);
    wb(1'b0, `IPC_OFS_COUNT, 32'h0);
    chk("count", rd, 32'h2);
    wb(1'b1, `IPC_OFS_CTRL, 32'h42);
    ipc_pulse_src_i.pulse(4'h3);
    wb(1'b0, `IPC_OFS_COUNT, 32'h0);
    chk("count idle", {rd[30:0], busy}, 32'h4);
    $display("test hand done");
    wsel = 4'h5;
    wb(1'b1, `IPC_OFS_PRESET, 32'hAABBCCDD);
    wsel = 4'hF;
    wb(1'b0, `IPC_OFS_PRESET, 32'h0);
    chk("preset lanes", rd, 32'h00BB00DD);
    wb(1'b1, `IPC_OFS_SEL, 32'hFFFFFFFF);
    wb(1'b0, `IPC_OFS_SEL, 32'h0);
    chk("sel fields", rd, 32'h000F0F07);
    $display("test lanes done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, `IPC_OFS_PRESET, 32'h0);
    chk("preset reset", rd, 32'h0);
    wb(1'b0, `IPC_OFS_COUNT, 32'h0);
    chk("count reset", rd, 32'h0);
    chk("count_o busy_o reset", cnt | {31'h0, busy}, 32'h0);
    $display("test reset mid done");
    results();
  end
endmodule

// file: ipc_defines.vh
// Purpose: Constants for the input pulse counter block
// Assumes: 32-bit classic Wishbone register access
// Notes: Byte offsets, field positions, reset values
`ifndef IPC_DEFINES_VH
`define IPC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IPC_OFS_CTRL 8'h00
`define IPC_OFS_SEL 8'h04
`define IPC_OFS_CYCLE 8'h08
`define IPC_OFS_PRESET 8'h0C
`define IPC_OFS_COUNT 8'h10
`define IPC_OFS_STATUS 8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define IPC_CTRL_EXEC 0
`define IPC_CTRL_START 1
`define IPC_CTRL_CLEAR 2
`define IPC_CTRL_LVL 3
`define IPC_CTRL_FALL 4
`define IPC_CTRL_RISE 5
`define IPC_CTRL_UP 6
`define IPC_CTRL_CYC 7
`define IPC_CTRL_PRE 8
`define IPC_CTRL_W 9

// ----------------------------------------------------------------
// Selection register fields
// ----------------------------------------------------------------
`define IPC_SEL_IDX_LO 0
`define IPC_SEL_IDX_HI 2
`define IPC_SEL_SRC_LO 8
`define IPC_SEL_SRC_HI 11
`define IPC_SEL_CLR_LO 16
`define IPC_SEL_CLR_HI 19

// ----------------------------------------------------------------
// Status register fields and limits
// ----------------------------------------------------------------
`define IPC_STAT_BUSY 0
`define IPC_STAT_VALID 1
`define IPC_STAT_ERR 2
`define IPC_IDX_MAX 3'h6
`define IPC_ERRID_IDX 16'h0001

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IPC_RST_CTRL 9'h040
`define IPC_RST_SEL 32'h00000000
`define IPC_RST_CYCLE 32'h00000000
`define IPC_RST_PRESET 32'h00000000

`endif

// file: ipc_pulse_src.sv
// Purpose: Pulse source on the digital input pins
// Assumes: Pins change just after a rising edge
// Notes: Each pulse is held three cycles high, then three cycles low
`timescale 1ns/1ps
module ipc_pulse_src (
  input wire clk_i,
  output logic [15:0] di_o
);
  initial di_o = 16'h0000;
  task pulse(input logic [3:0] ch);
    @(posedge clk_i);
    di_o[ch] <= 1'b1;
    repeat (3) @(posedge clk_i);
    di_o[ch] <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task pin(input logic [3:0] ch, input logic v);
    @(posedge clk_i);
    di_o[ch] <= v;
    repeat (3) @(posedge clk_i);
  endtask
endmodule
